// *** design/wit_pkg.sv ***
package wit_pkg;

	// Register byte offsets
	localparam logic [7:0] WIT_CTRL_OFS   = 8'h00;
	localparam logic [7:0] WIT_IRQ_OFS    = 8'h04;
	localparam logic [7:0] WIT_STAT_OFS   = 8'h08;

	// Control register field positions
	localparam int         WIT_CLR_LSB    = 4;
	localparam int         WIT_EN_BIT     = 3;
	localparam int         WIT_MODE_BIT   = 2;
	localparam int         WIT_INT_LSB    = 0;

	// Interrupt register field positions
	localparam int         WIT_FLAG_BIT   = 0;
	localparam int         WIT_IE_BIT     = 1;

	// Reset values
	localparam logic [3:0] WIT_CLR_RST    = 4'h0;
	localparam logic [1:0] WIT_INT_RST    = 2'h0;

	// Clear keys
	localparam logic [3:0] WIT_KEY_FIRST  = 4'ha;
	localparam logic [3:0] WIT_KEY_SECOND = 4'h5;

	// Counter width and interval lengths in low-speed periods
	localparam int          WIT_CNT_W     = 15;
	localparam logic [15:0] WIT_IVL_0     = 16'h0040;
	localparam logic [15:0] WIT_IVL_1     = 16'h0200;
	localparam logic [15:0] WIT_IVL_2     = 16'h2000;
	localparam logic [15:0] WIT_IVL_3     = 16'h8000;

	// Low-speed oscillator periods in ns, crystal and RC bounds
	localparam real         WIT_XTAL_NS   = 1.0e9 / 32768.0;
	localparam real         WIT_RC_MIN_NS = 1.0e9 / 36000.0;
	localparam real         WIT_RC_MAX_NS = 1.0e9 / 32000.0;

	typedef enum logic [2:0] {
		WIT_PM_ACTIVE,
		WIT_PM_IDLE,
		WIT_PM_LIGHT,
		WIT_PM_DEEP,
		WIT_PM_DEEPEST
	} wit_pmode_e;

endpackage

// *** design/wit_watchdog.sv ***
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module wit_watchdog (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              ls_clk,
	input  wire wit_pkg::wit_pmode_e power_mode,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	output logic                   sys_reset_req,
	output logic                   wdog_irq
);
	import wit_pkg::*;

	function automatic logic [1:0] reg_index(input logic [31:0] a);
		if (a == {24'h000000, WIT_CTRL_OFS}) begin
			return 2'h1;
		end else if (a == {24'h000000, WIT_IRQ_OFS}) begin
			return 2'h2;
		end else if (a == {24'h000000, WIT_STAT_OFS}) begin
			return 2'h3;
		end else begin
			return 2'h0;
		end
	endfunction

	logic                 pready_q;
	logic [31:0]          prdata_q;
	logic                 pslverr_q;
	logic                 ls_q;
	logic                 ls_prev_q;
	logic [3:0]           clr_q;
	logic                 en_q;
	logic                 mode_q;
	logic [1:0]           int_q;
	logic                 locked_q;
	logic                 armed_q;
	logic                 arm_lvl_q;
	logic                 clr_pend_q;
	logic                 start_pend_q;
	logic [WIT_CNT_W-1:0] cnt_q;
	logic                 expired_q;
	logic                 rst_req_q;
	logic                 flag_q;
	logic                 ie_q;
	logic                 irq_q;
	logic                 tick;
	logic                 wr_ctrl;
	logic                 wr_irq;
	logic                 first_acc;
	logic [15:0]          limit;
	logic                 hit;
	logic                 deep;
	logic                 awake;
	logic                 mode_new;
	logic                 key2_ok;
	logic                 tmr_hit;

	assign pready        = pready_q;
	assign prdata        = prdata_q;
	assign pslverr       = pslverr_q;
	assign sys_reset_req = rst_req_q;
	assign wdog_irq      = irq_q;

	// Bus strobes: writes land on the edge that completes the access
	assign first_acc = psel && penable && !pready_q;
	assign wr_ctrl   = psel && penable && pready_q && pwrite && (reg_index(paddr) == 2'h1);
	assign wr_irq    = psel && penable && pready_q && pwrite && (reg_index(paddr) == 2'h2);

	// Low-speed edge and power state
	assign tick     = ls_q && !ls_prev_q;
	assign deep     = (power_mode == WIT_PM_DEEP) || (power_mode == WIT_PM_DEEPEST);
	assign awake    = (power_mode == WIT_PM_ACTIVE) || (power_mode == WIT_PM_IDLE);
	assign mode_new = locked_q ? mode_q : pwdata[WIT_MODE_BIT];
	assign key2_ok  = armed_q && (arm_lvl_q == ls_q) &&
		(pwdata[WIT_CLR_LSB+3:WIT_CLR_LSB] == WIT_KEY_SECOND);

	// Interval limit
	always_comb begin
		case (int_q)
			2'h0: limit = WIT_IVL_0;
			2'h1: limit = WIT_IVL_1;
			2'h2: limit = WIT_IVL_2;
			default: limit = WIT_IVL_3;
		endcase
	end

	assign hit     = ({1'b0, cnt_q} + 16'h0001) == limit;
	assign tmr_hit = tick && en_q && mode_q && !deep && hit && !clr_pend_q && !start_pend_q;

	// APB slave, one wait state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= first_acc;
			pslverr_q <= first_acc && (reg_index(paddr) == 2'h0);
			if (first_acc && !pwrite) begin
				if (reg_index(paddr) == 2'h1) begin
					prdata_q <= {24'h000000, clr_q, en_q, mode_q, int_q};
				end else if (reg_index(paddr) == 2'h2) begin
					prdata_q <= {30'h00000000, ie_q, flag_q};
				end else if (reg_index(paddr) == 2'h3) begin
					prdata_q <= {29'h00000000, expired_q, locked_q, en_q};
				end else begin
					prdata_q <= 32'h00000000;
				end
			end
		end
	end

	// Low-speed clock sampling
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ls_q      <= 1'b0;
			ls_prev_q <= 1'b0;
		end else begin
			ls_q      <= ls_clk;
			ls_prev_q <= ls_q;
		end
	end

	// Control register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			clr_q    <= WIT_CLR_RST;
			en_q     <= 1'b0;
			mode_q   <= 1'b0;
			int_q    <= WIT_INT_RST;
			locked_q <= 1'b0;
		end else if (wr_ctrl) begin
			clr_q  <= pwdata[WIT_CLR_LSB+3:WIT_CLR_LSB];
			int_q  <= pwdata[WIT_INT_LSB+1:WIT_INT_LSB];
			mode_q <= mode_new;
			if (pwdata[WIT_EN_BIT]) begin
				en_q <= 1'b1;
				if (!mode_new) begin
					locked_q <= 1'b1;
				end
			end else if (!locked_q) begin
				en_q <= 1'b0;
			end
		end
	end

	// Clear key sequence and pending actions
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			armed_q      <= 1'b0;
			arm_lvl_q    <= 1'b0;
			clr_pend_q   <= 1'b0;
			start_pend_q <= 1'b0;
		end else begin
			if (wr_ctrl && en_q && !mode_q) begin
				armed_q   <= (pwdata[WIT_CLR_LSB+3:WIT_CLR_LSB] == WIT_KEY_FIRST);
				arm_lvl_q <= ls_q;
			end else if (armed_q && (arm_lvl_q != ls_q)) begin
				armed_q <= 1'b0;
			end
			if (wr_ctrl && en_q && !mode_q && key2_ok) begin
				clr_pend_q <= 1'b1;
			end else if (wr_ctrl && en_q && mode_q && pwdata[WIT_CLR_LSB]) begin
				clr_pend_q <= 1'b1;
			end else if (tick || deep) begin
				clr_pend_q <= 1'b0;
			end
			if (wr_ctrl && !en_q && pwdata[WIT_EN_BIT]) begin
				start_pend_q <= 1'b1;
			end else if (tick || deep) begin
				start_pend_q <= 1'b0;
			end
		end
	end

	// Counter
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (deep) begin
			cnt_q <= '0;
		end else if (tick) begin
			if (clr_pend_q || start_pend_q) begin
				cnt_q <= '0;
			end else if (en_q) begin
				if (!hit) begin
					cnt_q <= cnt_q + 15'h0001;
				end else if (mode_q) begin
					cnt_q <= '0;
				end
			end
		end
	end

	// Watchdog expiry and system reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			expired_q <= 1'b0;
			rst_req_q <= 1'b0;
		end else begin
			if (deep || (tick && clr_pend_q)) begin
				expired_q <= 1'b0;
			end else if (tick && en_q && !mode_q && hit && !armed_q && !start_pend_q) begin
				expired_q <= 1'b1;
			end
			if (expired_q && awake && !mode_q) begin
				rst_req_q <= 1'b1;
			end
		end
	end

	// Interrupt flag and enable
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flag_q <= 1'b0;
			ie_q   <= 1'b0;
			irq_q  <= 1'b0;
		end else begin
			if (tmr_hit) begin
				flag_q <= 1'b1;
			end else if (wr_irq && pwdata[WIT_FLAG_BIT]) begin
				flag_q <= 1'b0;
			end
			if (wr_irq) begin
				ie_q <= pwdata[WIT_IE_BIT];
			end
			irq_q <= flag_q && ie_q && mode_q;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Bus checks
	apb_ready_a: assert property (first_acc |=> pready_q && !first_acc)
		else $error("APB access not answered after one wait state");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("Ready held longer than one cycle");
	slverr_ready_a: assert property (pslverr |-> pready)
		else $error("Error response outside a completed access");
	int_write_a: assert property (wr_ctrl
		|=> int_q == $past(pwdata[WIT_INT_LSB+1:WIT_INT_LSB]))
		else $error("Interval field not written");

	// Counter checks
	ls_tick_a: assert property (tick |=> !tick)
		else $error("Low-speed edge seen twice");
	count_step_a: assert property (tick && en_q && !deep && !hit
		&& !clr_pend_q && !start_pend_q |=> cnt_q == $past(cnt_q) + 15'h0001)
		else $error("Counter did not step on a low-speed edge");
	start_off_a: assert property ($rose(en_q) |-> $past(wr_ctrl && pwdata[WIT_EN_BIT]))
		else $error("Timer enabled without a software write");
	start_zero_a: assert property ($rose(en_q) |-> start_pend_q)
		else $error("Enable did not schedule a restart from zero");
	stop_hold_a: assert property (!en_q && !deep && !tick |=> $stable(cnt_q))
		else $error("Stopped counter changed");
	clear_zero_a: assert property (tick && !deep && (clr_pend_q || start_pend_q)
		|=> cnt_q == '0)
		else $error("Pending clear did not zero the counter");
	pend_drop_a: assert property (tick && !wr_ctrl |=> !clr_pend_q)
		else $error("Pending clear outlived its low-speed edge");
	tmr_wrap_a: assert property (tmr_hit |=> cnt_q == '0)
		else $error("Timer counter did not restart after the interval");
	deep_zero_a: assert property (deep |=> cnt_q == '0)
		else $error("Counter not zeroed in deep sleep");
	sleep_keep_a: assert property (deep && !wr_ctrl |=> $stable({en_q, mode_q, int_q}))
		else $error("Configuration lost in deep sleep");

	// Watchdog checks
	lock_set_a: assert property ($rose(locked_q) |-> en_q && !mode_q)
		else $error("Lock taken outside watchdog operation");
	lock_hold_a: assert property (locked_q |=> en_q && !mode_q && locked_q)
		else $error("Locked watchdog left watchdog operation");
	mode_keep_a: assert property (locked_q && wr_ctrl |=> !mode_q)
		else $error("Mode changed while locked");
	key_first_a: assert property (wr_ctrl && en_q && !mode_q
		&& pwdata[WIT_CLR_LSB+3:WIT_CLR_LSB] == WIT_KEY_FIRST |=> armed_q)
		else $error("First clear key not armed");
	key_window_a: assert property (armed_q && arm_lvl_q != ls_q
		&& !wr_ctrl |=> !armed_q)
		else $error("Clear key outlived half a low-speed period");
	key_clear_a: assert property ($rose(clr_pend_q) && !$past(mode_q)
		|-> $past(armed_q))
		else $error("Watchdog clear accepted without the first key");
	no_clear_a: assert property (tick && en_q && !mode_q && hit && !armed_q && !deep
		&& !clr_pend_q && !start_pend_q |=> expired_q)
		else $error("Missed clear did not expire the watchdog");
	wd_reset_a: assert property (expired_q && awake && !mode_q |=> rst_req_q)
		else $error("Expired watchdog did not request reset");
	rst_sticky_a: assert property (rst_req_q |=> rst_req_q)
		else $error("Reset request dropped");
	sleep_hold_a: assert property ($past(power_mode) == WIT_PM_LIGHT
		|-> !$rose(rst_req_q))
		else $error("Reset raised during light sleep");
	deep_expiry_a: assert property (deep |=> !expired_q)
		else $error("Expiry kept in deep sleep");
	clr_off_a: assert property (wr_ctrl && !en_q |=> !$rose(clr_pend_q))
		else $error("Clear write acted while disabled");

	// Timer checks
	wd_no_irq_a: assert property ($rose(flag_q) |-> $past(mode_q))
		else $error("Interrupt flag set in watchdog mode");
	irq_mode_a: assert property (!$past(mode_q) |-> !wdog_irq)
		else $error("Interrupt raised outside timer mode");
	timer_irq_a: assert property (tmr_hit
		|=> flag_q ##1 (wdog_irq == $past(ie_q && mode_q)))
		else $error("Timer interval did not raise the flag");
	flag_clear_a: assert property (wr_irq && pwdata[WIT_FLAG_BIT]
		&& !tmr_hit |=> !flag_q)
		else $error("Interrupt flag not cleared by software");
	tmr_reset_a: assert property ($rose(rst_req_q) |-> !$past(mode_q))
		else $error("System reset raised in timer mode");

	// Covers
	wd_reset_c: cover property ($rose(rst_req_q));
	timer_irq_c: cover property ($rose(wdog_irq));
	key_clear_c: cover property ($rose(clr_pend_q) && !mode_q);
	sleep_expire_c: cover property (expired_q && power_mode == WIT_PM_LIGHT);
	tmr_clear_c: cover property (wr_ctrl && en_q && mode_q && pwdata[WIT_CLR_LSB]);

endmodule // wit_watchdog

// *** dv/wit_ls_osc.sv ***
`timescale 1ns/1ps
module wit_ls_osc #(
	parameter real HALF_NS = 400.0
) (
	output logic ls_clk
);
	// Free-running low-speed source, period scaled down to keep runs short
	initial begin
		ls_clk = 1'b0;
		#(HALF_NS * 0.37);
		forever #(HALF_NS) ls_clk = ~ls_clk;
	end
endmodule // wit_ls_osc

// *** dv/test_watchdog_interval_timer.sv ***
`timescale 1ns/1ps
module test_watchdog_interval_timer;
	import wit_pkg::*;
	logic        clk, rst_n, ls_clk, psel, penable, pwrite;
	logic        pready, pslverr, sys_reset_req, wdog_irq, e;
	logic [31:0] paddr, pwdata, prdata, rd;
	wit_pmode_e  power_mode;
	int          errors, n_compared, t, i;

	wit_ls_osc #(.HALF_NS(400.0)) osc (.ls_clk(ls_clk));
	wit_watchdog uut (.clk(clk), .rst_n(rst_n), .ls_clk(ls_clk), .power_mode(power_mode),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.sys_reset_req(sys_reset_req), .wdog_irq(wdog_irq));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task final_report;
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		n_compared++;
		if (g !== x) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, x, g);
		end
	endtask

	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			errors++;
		end
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rchk(input string n, input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, {24'h0, a}, 32'h0);
		chk(n, x, rd);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, {24'h0, a}, d);
	endtask

	task ticks(input int n);
		repeat (n) @(posedge ls_clk);
	endtask

	task wait_for(input int max, input logic irq, output int n);
		n = 0;
		repeat (4) @(posedge clk);
		while (((irq ? wdog_irq : sys_reset_req) !== 1'b1) && n < max) begin
			@(posedge ls_clk);
			n++;
		end
		repeat (4) @(posedge clk);
	endtask

	task in_win(input string n);
		chk(n, 32'h1, {31'h0, (t >= 60 && t <= 68)});
	endtask

	task wd_clear(input logic [3:0] second);
		@(posedge ls_clk);
		wr(WIT_CTRL_OFS, 32'ha8);
		wr(WIT_CTRL_OFS, {24'h0, second, 4'h8});
	endtask

	task pm(input wit_pmode_e m);
		@(posedge clk);
		power_mode <= m;
	endtask

	task do_reset;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask

	initial begin
		#1_500_000;
		errors++;
		final_report;
	end

	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		power_mode = WIT_PM_ACTIVE;
		errors = 0;
		n_compared = 0;
		do_reset;
		rchk("ctrl", WIT_CTRL_OFS, 32'h0);
		rchk("status", WIT_STAT_OFS, 32'h0);
		apb(1'b0, 32'h0000000c, 32'h0);
		chk("slverr", 32'h1, {31'h0, e});
		$display("reset test done");
		wr(WIT_IRQ_OFS, 32'h2);
		wr(WIT_CTRL_OFS, 32'h0c);
		rchk("ctrl", WIT_CTRL_OFS, 32'h0c);
		wait_for(80, 1'b1, t);
		in_win("irq interval");
		rchk("irq", WIT_IRQ_OFS, 32'h3);
		chk("no reset", 32'h0, {31'h0, sys_reset_req});
		wr(WIT_IRQ_OFS, 32'h3);
		wait_for(80, 1'b1, t);
		in_win("irq period");
		wr(WIT_IRQ_OFS, 32'h1);
		wait_for(80, 1'b1, t);
		chk("irq masked", 32'h0, {31'h0, wdog_irq});
		rchk("flag only", WIT_IRQ_OFS, 32'h1);
		wr(WIT_IRQ_OFS, 32'h1);
		for (i = 0; i < 3; i++) begin
			ticks(40);
			wr(WIT_CTRL_OFS, 32'h1c);
		end
		rchk("cleared", WIT_IRQ_OFS, 32'h0);
		ticks(30);
		wr(WIT_CTRL_OFS, 32'h04);
		rchk("stopped", WIT_STAT_OFS, 32'h0);
		ticks(80);
		rchk("no flag", WIT_IRQ_OFS, 32'h0);
		wr(WIT_CTRL_OFS, 32'h07);
		rchk("ivl code", WIT_CTRL_OFS, 32'h07);
		wr(WIT_IRQ_OFS, 32'h2);
		wr(WIT_CTRL_OFS, 32'h0c);
		wait_for(80, 1'b1, t);
		in_win("timer restart");
		$display("timer test done");
		do_reset;
		pm(WIT_PM_IDLE);
		wr(WIT_CTRL_OFS, 32'h09);
		rchk("locked", WIT_STAT_OFS, 32'h3);
		wr(WIT_CTRL_OFS, 32'h05);
		rchk("kept", WIT_CTRL_OFS, 32'h09);
		wr(WIT_CTRL_OFS, 32'h08);
		wd_clear(4'h5);
		for (i = 0; i < 3; i++) begin
			ticks(40);
			wd_clear(4'h5);
		end
		chk("no reset", 32'h0, {31'h0, sys_reset_req});
		chk("no irq", 32'h0, {31'h0, wdog_irq});
		wd_clear(4'h3);
		wait_for(80, 1'b0, t);
		in_win("timeout");
		$display("watchdog test done");
		do_reset;
		wr(WIT_CTRL_OFS, 32'h08);
		pm(WIT_PM_LIGHT);
		wait_for(80, 1'b0, t);
		chk("sleep reset", 32'h0, {31'h0, sys_reset_req});
		rchk("expired", WIT_STAT_OFS, 32'h7);
		pm(WIT_PM_ACTIVE);
		repeat (4) @(posedge clk);
		chk("wake reset", 32'h1, {31'h0, sys_reset_req});
		$display("light sleep test done");
		for (i = 0; i < 2; i++) begin
			do_reset;
			wr(WIT_CTRL_OFS, 32'h08);
			ticks(40);
			pm(i == 0 ? WIT_PM_DEEP : WIT_PM_DEEPEST);
			ticks(40);
			pm(WIT_PM_ACTIVE);
			rchk("config", WIT_CTRL_OFS, 32'h08);
			wait_for(80, 1'b0, t);
			in_win("restart");
		end
		$display("deep sleep test done");
		final_report;
	end
endmodule // test_watchdog_interval_timer
